/* File: core/hfcrc_section.sv */
// One CRC section: bit pipeline FIFO plus the framing and check value logic
`timescale 1ns/1ps
`default_nettype none

// Bit pipeline; resets and fills to full of mark bits
module hfcrc_fifo #(
    parameter int         W         = 1,
    parameter int         DEPTH     = 8,
    parameter logic [W-1:0] FILL_VAL = '1
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         fill,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == LAST_PTR) ? '0 : p + AW'(1);
    endfunction

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= FILL_VAL;
            end
        end else if (fill) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= FILL_VAL;
            end
        end else if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= FULL_CNT;
        end else if (fill) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= FULL_CNT;
        end else begin
            if (push) begin
                wr_q <= next_ptr(wr_q);
            end
            if (pop) begin
                rd_q <= next_ptr(rd_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + CW'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end
endmodule

module hfcrc_section
    import hfcrc_pkg::*;
#(
    parameter int PIPE_W = 1,
    parameter int DEPTH  = PIPE_DEPTH
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              bit_clock_in,
    input  wire logic              serial_in,
    input  wire hfcrc_pkg::hfcrc_ctl_t ctl,
    output logic                   gated_clock_out,
    output logic                   serial_out,
    output hfcrc_pkg::hfcrc_sts_t  sts
);
    import hfcrc_pkg::*;

    // Pin synchronisers; stage one feeds stage two only
    logic       clk_s1_q, clk_s2_q, clk_s3_q;
    logic       ser_s1_q, ser_s2_q;
    hfcrc_ctl_t ctl_s1_q, ctl_s2_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            ser_s1_q <= LINE_MARK;
            ser_s2_q <= LINE_MARK;
            ctl_s1_q <= '0;
            ctl_s2_q <= '0;
        end else begin
            clk_s1_q <= bit_clock_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            ser_s1_q <= serial_in;
            ser_s2_q <= ser_s1_q;
            ctl_s1_q <= ctl;
            ctl_s2_q <= ctl_s1_q;
        end
    end

    logic tick, mreset;
    assign tick   = clk_s2_q && !clk_s3_q;
    assign mreset = ctl_s2_q.master_reset;

    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : '0);
    endfunction

    // Section state
    hfcrc_state_t     state_q;
    logic             en_q, chk_q;
    logic             push_ph_q;
    logic             in_bit_q;
    logic [7:0]       hist_q;
    logic [2:0]       in_ones_q;
    logic [3:0]       skip_q;
    logic [2:0]       pop_ones_q;
    logic             pend_q;
    logic [4:0]       sig_q;
    logic [CRC_W-1:0] crc_q;
    logic [CRC_W-1:0] send_q;
    logic [5:0]       sent_q;
    logic [2:0]       out_ones_q;
    logic             serial_out_q;
    logic             gclk_q;
    logic             err_q;
    logic             err_flag_q;

    // Pipeline: eight bits in the FIFO plus the output flop give nine bit times
    logic    fifo_in_ready;
    logic    fifo_out_valid;
    logic    fifo_pop;
    logic    fifo_push;
    logic [PIPE_W-1:0] fifo_out;
    logic    sending;

    assign sending   = (state_q == HFCRC_SEND);
    assign fifo_pop  = tick && !sending;
    assign fifo_push = push_ph_q && !sending && fifo_in_ready;

    hfcrc_fifo #(
        .W        (PIPE_W),
        .DEPTH    (DEPTH),
        .FILL_VAL ({PIPE_W{LINE_MARK}})
    ) u_pipe (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .fill      (mreset),
        .in_valid  (push_ph_q && !sending),
        .in_ready  (fifo_in_ready),
        .in_data   ({PIPE_W{in_bit_q}}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Sample the line on each bit clock rise, push one cycle later
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            push_ph_q <= 1'b0;
            in_bit_q  <= LINE_MARK;
            en_q      <= 1'b0;
            chk_q     <= 1'b0;
        end else begin
            push_ph_q <= tick;
            if (tick) begin
                in_bit_q <= ser_s2_q;
                en_q     <= ctl_s2_q.crc_enable;
                chk_q    <= ctl_s2_q.check_not_generate;
            end
        end
    end

    // Entry side: flag and abort detection on bits entering the pipeline
    logic [7:0] hist_d;
    logic       flag_hit;
    logic       abort_hit;
    logic       pop_bit;
    logic       stuffed;
    assign hist_d    = {hist_q[6:0], in_bit_q};
    assign flag_hit  = (hist_d == FLAG_PATTERN);
    assign abort_hit = in_bit_q && (in_ones_q == ABORT_RUN);
    assign pop_bit   = fifo_out[0] && fifo_out_valid;
    assign stuffed   = !pop_bit && (pop_ones_q == STUFF_RUN);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hist_q    <= '0;
            in_ones_q <= '0;
        end else if (mreset) begin
            hist_q    <= '0;
            in_ones_q <= '0;
        end else if (fifo_push) begin
            hist_q    <= hist_d;
            in_ones_q <= !in_bit_q ? 3'd0 :
                         (in_ones_q == 3'd7) ? in_ones_q : in_ones_q + 3'd1;
        end
    end

    // Frame state, accumulation and check value
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q    <= HFCRC_HUNT;
            crc_q      <= CRC_INIT;
            skip_q     <= '0;
            pop_ones_q <= '0;
            pend_q     <= 1'b0;
            sig_q      <= '0;
            send_q     <= '0;
            sent_q     <= '0;
            err_q      <= 1'b0;
        end else if (mreset) begin
            state_q    <= HFCRC_HUNT;
            crc_q      <= CRC_INIT;
            pend_q     <= 1'b0;
            sig_q      <= '0;
            err_q      <= 1'b0;
        end else if (sending) begin
            if (tick && out_ones_q != STUFF_RUN) begin
                send_q <= send_q >> 1;
                sent_q <= sent_q + 6'd1;
            end
            if (tick && (sent_q == CRC_BITS ||
                         (sent_q == CRC_BITS - 6'd1 && out_ones_q != STUFF_RUN &&
                          !(send_q[0] && out_ones_q == PEND_RUN)))) begin
                state_q <= HFCRC_FRAME;
            end
        end else if (fifo_push) begin
            if (!en_q) begin
                state_q <= HFCRC_HUNT;
            end else if (abort_hit) begin
                state_q <= HFCRC_HUNT;
                pend_q  <= 1'b0;
            end else if (flag_hit) begin
                // A pending fifth one is dropped here: that was no stuffing point
                if (state_q == HFCRC_FRAME && skip_q == '0 && sig_q >= MIN_SIG_BITS) begin
                    if (chk_q) begin
                        err_q <= (crc_q != CRC_RESIDUE);
                    end else begin
                        state_q <= HFCRC_SEND;
                        send_q  <= ~crc_q;
                        sent_q  <= '0;
                    end
                end
                if (!(state_q == HFCRC_FRAME && skip_q == '0 && sig_q >= MIN_SIG_BITS)
                    || chk_q) begin
                    state_q <= HFCRC_FRAME;
                end
                crc_q      <= CRC_INIT;
                skip_q     <= FLAG_SKIP;
                pop_ones_q <= '0;
                pend_q     <= 1'b0;
                sig_q      <= '0;
            end
        end else if (fifo_pop && state_q == HFCRC_FRAME && en_q) begin
            if (skip_q != '0) begin
                skip_q <= skip_q - 4'd1;
            end else begin
                pop_ones_q <= pop_bit ? pop_ones_q + 3'd1 : 3'd0;
                if (stuffed) begin
                    // Committing the held one only now keeps it out at a closing flag
                    if (pend_q) begin
                        crc_q <= crc_step(crc_q, 1'b1);
                    end
                    pend_q <= 1'b0;
                end else if (pop_bit && pop_ones_q == PEND_RUN) begin
                    pend_q <= 1'b1;
                end else begin
                    crc_q  <= pend_q ? crc_step(crc_step(crc_q, 1'b1), pop_bit)
                                     : crc_step(crc_q, pop_bit);
                    pend_q <= 1'b0;
                    if (sig_q < MIN_SIG_BITS) begin
                        sig_q <= sig_q + (pend_q ? 5'd2 : 5'd1);
                    end
                end
                if (stuffed && pend_q && sig_q < MIN_SIG_BITS) begin
                    sig_q <= sig_q + 5'd1;
                end
            end
        end
    end

    // Line side: output flop, run of ones on the wire, gated clock
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            serial_out_q <= LINE_MARK;
            out_ones_q   <= '0;
            gclk_q       <= 1'b0;
        end else begin
            gclk_q <= sending ? 1'b1 : clk_s2_q;
            if (mreset) begin
                serial_out_q <= LINE_MARK;
                out_ones_q   <= '0;
            end else if (tick) begin
                if (sending) begin
                    serial_out_q <= (out_ones_q == STUFF_RUN) ? 1'b0 : send_q[0];
                    out_ones_q   <= (out_ones_q == STUFF_RUN || !send_q[0]) ? 3'd0
                                    : out_ones_q + 3'd1;
                end else begin
                    serial_out_q <= pop_bit;
                    out_ones_q   <= !pop_bit ? 3'd0 :
                                    (out_ones_q == 3'd7) ? out_ones_q : out_ones_q + 3'd1;
                end
            end
        end
    end

    // Sticky error flag; a held clear outranks a new error
    logic err_set;
    assign err_set = fifo_push && en_q && chk_q && flag_hit && !abort_hit && !mreset &&
                     state_q == HFCRC_FRAME && skip_q == '0 && sig_q >= MIN_SIG_BITS &&
                     crc_q != CRC_RESIDUE;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            err_flag_q <= 1'b0;
        end else if (mreset || ctl_s2_q.error_flag_clear) begin
            err_flag_q <= 1'b0;
        end else if (err_set) begin
            err_flag_q <= 1'b1;
        end
    end

    assign gated_clock_out    = gclk_q;
    assign serial_out         = serial_out_q;
    assign sts                = '{crc_error_flag: err_flag_q, crc_error: err_q};
endmodule

`default_nettype wire

/* File: inc/hfcrc_pkg.sv */
// Shared constants and types for the serial frame CRC section
package hfcrc_pkg;

    // Bit-level framing
    localparam int          PIPE_DEPTH   = 8;
    localparam int          BIT_DELAY    = 9;
    localparam logic [7:0]  FLAG_PATTERN = 8'h7E;
    localparam logic [2:0]  STUFF_RUN    = 3'd5;
    localparam logic [2:0]  ABORT_RUN    = 3'd6;
    localparam logic [2:0]  PEND_RUN     = 3'd4;
    localparam logic [4:0]  MIN_SIG_BITS = 5'd16;
    localparam logic [3:0]  FLAG_SKIP    = 4'd8;

    // Check value arithmetic, reflected form, LSB first on the line
    localparam int          CRC_W        = 32;
    localparam logic [31:0] CRC_POLY     = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB_20E3;
    localparam logic [5:0]  CRC_BITS     = 6'd32;

    // Line reset value and synchroniser depth
    localparam logic        LINE_MARK    = 1'b1;
    localparam int          SYNC_STAGES  = 2;

    typedef enum logic [1:0] {
        HFCRC_HUNT,
        HFCRC_FRAME,
        HFCRC_SEND
    } hfcrc_state_t;

    // Static control pins of one section
    typedef struct packed {
        logic crc_enable;
        logic check_not_generate;
        logic error_flag_clear;
        logic master_reset;
    } hfcrc_ctl_t;

    // Status returned to the system
    typedef struct packed {
        logic crc_error_flag;
        logic crc_error;
    } hfcrc_sts_t;

endpackage

/* File: tb/hfcrc_section_sva.sv */
// Concurrent checks on the ports of one CRC section
`timescale 1ns/1ps
`default_nettype none

module hfcrc_section_chk
    import hfcrc_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  bit_clock_in,
    input wire logic                  serial_in,
    input wire hfcrc_pkg::hfcrc_ctl_t ctl,
    input wire logic                  gated_clock_out,
    input wire logic                  serial_out,
    input wire hfcrc_pkg::hfcrc_sts_t sts
);
    // Thirty-two check bits plus worst-case stuffing, at sixteen ref_clk per bit
    localparam int STALL_MAX = 640;

    logic [9:0] hi_cnt_q;
    logic [3:0] clr_age_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hi_cnt_q <= 10'h000;
        end else if (!gated_clock_out) begin
            hi_cnt_q <= 10'h000;
        end else if (hi_cnt_q != 10'h3FF) begin
            hi_cnt_q <= hi_cnt_q + 10'h001;
        end
    end

    // Age since a clear or master reset was last seen, saturating
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clr_age_q <= 4'hF;
        end else if (ctl.error_flag_clear || ctl.master_reset) begin
            clr_age_q <= 4'h0;
        end else if (clr_age_q != 4'hF) begin
            clr_age_q <= clr_age_q + 4'h1;
        end
    end

    sequence s_mr_held;
        ctl.master_reset [*5];
    endsequence
    sequence s_clr_held;
        ctl.error_flag_clear [*5];
    endsequence

    chk_reset_idle: assert property (
        $fell(reset) |-> serial_out && !gated_clock_out && sts == 2'b00) else $error("outputs not idle");
    chk_mreset_force: assert property (
        s_mr_held |-> serial_out && sts == 2'b00) else $error("master reset not forcing");
    chk_clear_holds: assert property (
        s_clr_held |-> !sts.crc_error_flag) else $error("held clear let flag set");
    chk_flag_cause: assert property (
        $fell(sts.crc_error_flag) |-> clr_age_q < 4'h6) else $error("flag fell on its own");
    chk_flag_set: assert property (
        $rose(sts.crc_error_flag) |-> sts.crc_error && ctl.crc_enable && ctl.check_not_generate)
        else $error("flag set outside check");
    chk_gate_rise: assert property (
        $rose(gated_clock_out) |-> bit_clock_in) else $error("gated clock rose early");
    chk_gate_fall: assert property (
        $fell(gated_clock_out) |-> !bit_clock_in) else $error("gated clock fell early");
    chk_stall_mode: assert property (
        hi_cnt_q > 10'd16 |-> ctl.crc_enable && !ctl.check_not_generate) else $error("stall outside generate");
    chk_stall_bound: assert property (
        hi_cnt_q <= STALL_MAX) else $error("stall too long");
    chk_out_tick: assert property (
        $changed(serial_out) && !ctl.master_reset |-> bit_clock_in) else $error("output moved off tick");
endmodule

bind hfcrc_section hfcrc_section_chk i_chk (.ref_clk(ref_clk), .reset(reset),
    .bit_clock_in(bit_clock_in), .serial_in(serial_in), .ctl(ctl),
    .gated_clock_out(gated_clock_out), .serial_out(serial_out), .sts(sts));

`default_nettype wire

/* File: tb/hfcrc_ctrl_model.sv */
// Serial controller stand-in: free bit clock, data stepped on gated clock falls
`timescale 1ns/1ps
`default_nettype none

module hfcrc_ctrl_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic gated_clock_out,
    output logic      bit_clock,
    output logic      ser_data
);
    logic q[$];
    int   ph_q;
    logic gate_d_q;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ph_q <= 0;
            bit_clock <= 1'b0;
        end else begin
            ph_q <= (ph_q == BIT_CYC - 1) ? 0 : ph_q + 1;
            bit_clock <= (ph_q < BIT_CYC / 2);
        end
    end

    // Idle line is mark; a stall of the gated clock freezes the current bit
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gate_d_q <= 1'b0;
            ser_data <= 1'b1;
        end else begin
            gate_d_q <= gated_clock_out;
            if (gate_d_q && !gated_clock_out) begin
                ser_data <= (q.size() != 0) ? q.pop_front() : 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: tb/test_hfcrc_section.sv */
// Self-checking bench for one CRC section
`timescale 1ns/1ps
`default_nettype none

module test_hfcrc_section;
    import hfcrc_pkg::*;
    logic        ref_clk, reset, bit_clock, ser_data, gated_clock_out, serial_out;
    hfcrc_ctl_t  ctl;
    hfcrc_sts_t  sts;
    int          n_mismatch, total_checks, run;
    logic [31:0] crc;
    logic        e[$], cap_in[$], cap_out[$];
    int          gate_hi, gate_max;

    hfcrc_section i_dut (.ref_clk(ref_clk), .reset(reset), .bit_clock_in(bit_clock),
        .serial_in(ser_data), .ctl(ctl), .gated_clock_out(gated_clock_out),
        .serial_out(serial_out), .sts(sts));
    hfcrc_ctrl_model #(.BIT_CYC(16)) i_ctrl (.ref_clk(ref_clk), .reset(reset),
        .gated_clock_out(gated_clock_out), .bit_clock(bit_clock), .ser_data(ser_data));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Longest run of gated clock high, to see the stall
    always @(posedge ref_clk) begin
        gate_hi <= gated_clock_out ? gate_hi + 1 : 0;
        if (gate_hi > gate_max) gate_max <= gate_hi;
    end

    // Line sampled at the pin rise, well clear of both signals' changes
    always @(posedge bit_clock) begin
        cap_in.push_back(ser_data);
        cap_out.push_back(serial_out);
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task set_ctl(input logic en, input logic cng, input logic clr, input logic mr);
        @(posedge ref_clk);
        ctl <= {en, cng, clr, mr};
    endtask

    task tx(input logic b, input logic m);
        if (m) i_ctrl.q.push_back(b);
        e.push_back(b);
        run = b ? run + 1 : 0;
        if (run == 5) begin
            if (m) i_ctrl.q.push_back(1'b0);
            e.push_back(1'b0);
            run = 0;
        end
    endtask

    task flag;
        for (int i = 0; i < 8; i++) begin
            i_ctrl.q.push_back(FLAG_PATTERN[i]);
            e.push_back(FLAG_PATTERN[i]);
        end
        run = 0;
        crc = CRC_INIT;
    endtask

    task byte_out(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            crc = (crc >> 1) ^ ((crc[0] ^ v[i]) ? CRC_POLY : 32'h0000_0000);
            tx(v[i], 1'b1);
        end
    endtask

    task fcs(input logic m, input logic bad);
        logic [31:0] f;
        f = ~crc ^ {31'h0000_0000, bad};
        for (int i = 0; i < 32; i++) tx(f[i], m);
    endtask

    task ones(input int n);
        repeat (n) begin
            i_ctrl.q.push_back(1'b1);
            e.push_back(1'b1);
        end
        run = 0;
    endtask

    task start;
        e.delete();
        cap_in.delete();
        cap_out.delete();
        gate_max = 0;
        run = 0;
        ones(12);
    endtask

    // Opening flag, then a body with a run of five ones that needs a stuffed zero
    task frame_body;
        flag;
        byte_out(8'hF8);
        byte_out(8'h01);
        byte_out(8'h3C);
    endtask

    task drain;
        int g;
        g = 0;
        while (i_ctrl.q.size() != 0 && g < 20000) begin
            @(posedge ref_clk);
            g++;
        end
        if (g >= 20000) n_mismatch++;
        repeat (64) @(posedge bit_clock);
    endtask

    task t_disabled;
        set_ctl(1'b0, 1'b1, 1'b0, 1'b0);
        start;
        frame_body;
        byte_out(8'hA5);
        flag;
        ones(12);
        drain;
        for (int s = 9; s < cap_out.size(); s++) check(cap_out[s], cap_in[s - 9]);
        check(sts, 2'b00);
        $display("test disabled finished");
    endtask

    task t_generate;
        int pl, s, k, hit;
        set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
        start;
        frame_body;
        pl = e.size();
        fcs(1'b0, 1'b0);
        flag;
        byte_out(8'h55);
        ones(12);
        drain;
        hit = -1;
        for (s = 0; s + e.size() <= cap_out.size() && hit < 0; s++) begin
            k = 0;
            while (k < pl && cap_out[s + k] === e[k]) k++;
            if (k == pl) hit = s;
        end
        check(hit >= 0, 1'b1);
        for (k = pl; hit >= 0 && k < e.size(); k++) check(cap_out[hit + k], e[k]);
        check(gate_max >= 32 * 16, 1'b1);
        $display("test generate finished");
    endtask

    task chk_frame(input logic bad, input logic [1:0] exp);
        start;
        frame_body;
        fcs(1'b1, bad);
        flag;
        ones(12);
        drain;
        check(sts, exp);
        check(gate_max < 12, 1'b1);
    endtask

    task t_check;
        set_ctl(1'b1, 1'b1, 1'b0, 1'b0);
        chk_frame(1'b0, 2'b00);
        chk_frame(1'b1, 2'b11);
        set_ctl(1'b1, 1'b1, 1'b1, 1'b0);
        repeat (8) @(posedge ref_clk);
        set_ctl(1'b1, 1'b1, 1'b0, 1'b0);
        repeat (8) @(posedge ref_clk);
        check(sts, 2'b01);
        start;
        flag;
        byte_out(8'h3C);
        flag;
        ones(12);
        drain;
        check(sts, 2'b01);
        start;
        flag;
        byte_out(8'hF8);
        byte_out(8'h01);
        ones(8);
        flag;
        ones(12);
        drain;
        check(sts, 2'b01);
        chk_frame(1'b0, 2'b00);
        set_ctl(1'b1, 1'b1, 1'b1, 1'b0);
        chk_frame(1'b1, 2'b01);
        set_ctl(1'b1, 1'b1, 1'b0, 1'b0);
        $display("test check finished");
    endtask

    task t_mreset;
        set_ctl(1'b1, 1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge ref_clk);
        check(sts, 2'b00);
        check(serial_out, 1'b1);
        set_ctl(1'b1, 1'b1, 1'b0, 1'b0);
        $display("test master reset finished");
    endtask

    initial begin
        #200us;
        n_mismatch++;
        $display("watchdog expired");
        complete_run;
    end

    initial begin
        reset = 1'b1;
        ctl = '0;
        n_mismatch = 0;
        total_checks = 0;
        gate_hi = 0;
        gate_max = 0;
        crc = CRC_INIT;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_disabled;
        t_generate;
        t_check;
        t_mreset;
        complete_run;
    end
endmodule

`default_nettype wire
